// ===== core/cmcc_params.svh
`ifndef CMCC_PARAMS_SVH
`define CMCC_PARAMS_SVH
// Register byte offsets.
`define CMCC_OFF_CTRL 8'h00
`define CMCC_OFF_DISP 8'h04
`define CMCC_OFF_CFG 8'h08
`define CMCC_OFF_STAT 8'h0c
`define CMCC_OFF_ACC 8'h10
`define CMCC_OFF_DTR 8'h14
// Control field positions.
`define CMCC_CTRL_TEST_INH 0
`define CMCC_CTRL_OP_LOOP 1
`define CMCC_CTRL_STEP 2
`define CMCC_CTRL_LDR_EN 3
// Reset values.
`define CMCC_CTRL_RST 4'h0
`define CMCC_DISP_RST 16'h0000
`define CMCC_CFG_RST 2'h3
// Geometry: module word bits, stack select position, loader words.
`define CMCC_MOD_AW 12
`define CMCC_STK_LSB 13
`define CMCC_LOADER_WORDS 15'h003f
// Timing.
`define CMCC_CLK_NS 20
`define CMCC_RD_TIME_NS 400
`define CMCC_WR_TIME_NS 400
`define CMCC_RD_CYC ((`CMCC_RD_TIME_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS)
`define CMCC_WR_CYC ((`CMCC_WR_TIME_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS)
`endif

// ===== core/cmcc_pkg.sv
package cmcc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_DONE
  } cmcc_state_t;
  typedef logic [14:0] cmcc_addr_t;
  typedef logic [16:0] cmcc_word_t;
endpackage

// ===== core/cmcc_axil.sv
`timescale 1ns/1ps
module cmcc_axil (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side
  output logic reg_wr,
  output logic [7:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_werr,
  output logic [7:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rerr
);
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [3:0] ws_ff, nxt_ws;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;

  assign s_awready = !aw_ff && !bv_ff;
  assign s_wready = !w_ff && !bv_ff;
  assign s_arready = !rv_ff;
  assign reg_wr = aw_ff && w_ff && !bv_ff;
  assign reg_waddr = awa_ff;
  assign reg_wdata = wd_ff;
  assign reg_wstrb = ws_ff;
  assign reg_raddr = s_araddr;
  assign s_bvalid = bv_ff;
  assign s_bresp = br_ff;
  assign s_rvalid = rv_ff;
  assign s_rdata = rd_ff;
  assign s_rresp = rr_ff;

  always_comb begin
    nxt_aw = aw_ff;
    nxt_awa = awa_ff;
    nxt_w = w_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_awvalid && s_awready) begin
      nxt_aw = 1'b1;
      nxt_awa = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      nxt_w = 1'b1;
      nxt_wd = s_wdata;
      nxt_ws = s_wstrb;
    end
    if (reg_wr) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = reg_werr ? 2'h2 : 2'h0;
    end else if (bv_ff && s_bready) begin
      nxt_bv = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      nxt_rv = 1'b1;
      nxt_rd = reg_rdata;
      nxt_rr = reg_rerr ? 2'h2 : 2'h0;
    end else if (rv_ff && s_rready) begin
      nxt_rv = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      awa_ff <= 8'h00;
      w_ff <= 1'b0;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= 2'h0;
    end else begin
      aw_ff <= nxt_aw;
      awa_ff <= nxt_awa;
      w_ff <= nxt_w;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end
endmodule

// ===== core/cmcc_core_array.sv
`timescale 1ns/1ps
module cmcc_core_array (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Drive and sense
  input wire logic [14:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [16:0] inhibit,
  output logic [16:0] sense
);
  logic [16:0] cores [0:32767];
  logic [16:0] sense_ff;

  assign sense = sense_ff;

  // A read switches every core of the word to zero; only ones give a
  // sense pulse. A write tries to set every core and the inhibit keeps
  // the marked ones at zero, so the word must have been read first.
  always_ff @(posedge aclk) begin
    if (rd_stb) begin
      cores[addr] <= 17'h00000;
    end else if (wr_stb) begin
      cores[addr] <= cores[addr] | ~inhibit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_ff <= 17'h00000;
    end else if (rd_stb) begin
      sense_ff <= cores[addr];
    end
  end
endmodule

// ===== core/cmcc_top.sv
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cmcc_params.svh"
// Overview of operation
// R1 - Words live in 4096-word modules; two modules pair into one 8192-word stack.
// R2 - One to four stacks, 32768 words at most; absent stacks are never driven.
// R3 - The processor loads the word address before asking for a read.
// R4 - A read clears every bit of the addressed word; only the transfer register keeps it.
// R5 - Each sensed one sets its transfer register bit; the rest stay zero.
// R6 - Every read is followed in the same cycle by a restore to that address.
// R7 - Restore or write drives ones everywhere, inhibiting positions whose register bit is zero.
// R8 - A write still reads, discards the sensed word and stores the source-bus word.
// R9 - Fill mode writes one operator test word, from the display register, everywhere.
// R10 - Fill is allowed only while halted, with loop and step controls set.
// R11 - Loader locations are filled only while the loader enable is set.
// R12 - Fill keeps stepping the address while the step control is held.
// R13 - The loop can instead read successive locations into the A accumulator.
// R14 - Each word is seventeen bits: sixteen data bits and one extra bit.
// R15 - Sensing is gated by the read window, inhibit by its pulse in the write window.
// R16 - Address and transfer register stay fixed until the cycle ends, then new access.
module cmcc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor side
  input wire logic cpu_mar_load,
  input wire logic [14:0] cpu_mar_in,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_sbus,
  input wire logic cpu_halted,
  output logic cpu_ready,
  output logic cpu_done,
  output logic [15:0] cpu_rdata,
  // Core timing
  output logic read_time_window,
  output logic write_time_window,
  output logic inhibit_time_pulse,
  output logic [16:0] inhibit_drive
);

  // --------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------

  logic reg_wr, reg_werr, reg_rerr;
  logic [7:0] reg_waddr, reg_raddr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] reg_wstrb;

  cmcc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_axi_awaddr),
    .s_awvalid(s_axi_awvalid),
    .s_awready(s_axi_awready),
    .s_wdata(s_axi_wdata),
    .s_wstrb(s_axi_wstrb),
    .s_wvalid(s_axi_wvalid),
    .s_wready(s_axi_wready),
    .s_bresp(s_axi_bresp),
    .s_bvalid(s_axi_bvalid),
    .s_bready(s_axi_bready),
    .s_araddr(s_axi_araddr),
    .s_arvalid(s_axi_arvalid),
    .s_arready(s_axi_arready),
    .s_rdata(s_axi_rdata),
    .s_rresp(s_axi_rresp),
    .s_rvalid(s_axi_rvalid),
    .s_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_werr(reg_werr),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rerr(reg_rerr)
  );

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------

  cmcc_pkg::cmcc_state_t state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  cmcc_pkg::cmcc_addr_t mar_ff, nxt_mar;
  cmcc_pkg::cmcc_addr_t cyc_addr_ff, nxt_cyc_addr;
  cmcc_pkg::cmcc_addr_t fill_addr_ff, nxt_fill_addr;
  cmcc_pkg::cmcc_word_t dtr_ff, nxt_dtr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic wr_cyc_ff, nxt_wr_cyc;
  logic fill_cyc_ff, nxt_fill_cyc;
  logic [15:0] acc_ff, nxt_acc;
  logic done_ff, nxt_done;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic [15:0] disp_ff, nxt_disp;
  logic [1:0] cfg_ff, nxt_cfg;

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------

  cmcc_pkg::cmcc_addr_t top_addr;
  logic stack_ok, fill_arm, fill_write, loader_hit;
  logic rd_stb, wr_stb, rd_last, wr_last;
  cmcc_pkg::cmcc_word_t sense;

  // Address bits [11:0] pick a word in a module, bit 12 picks the module
  // of a stack by X current direction, bits [14:13] pick the stack.
  assign top_addr = {cfg_ff, 13'h1fff}; // see R1
  assign stack_ok = cyc_addr_ff[14:`CMCC_STK_LSB] <= cfg_ff; // see R2
  assign fill_arm = cpu_halted && ctrl_ff[`CMCC_CTRL_OP_LOOP]
    && ctrl_ff[`CMCC_CTRL_STEP]; // see R10
  assign fill_write = ctrl_ff[`CMCC_CTRL_TEST_INH]; // see R13
  assign loader_hit = fill_addr_ff > (top_addr - `CMCC_LOADER_WORDS);
  assign rd_last = cnt_ff == 5'(`CMCC_RD_CYC - 1);
  assign wr_last = cnt_ff == 5'(`CMCC_WR_CYC - 1);

  assign read_time_window = state_ff == cmcc_pkg::ST_READ; // see R15
  assign write_time_window = state_ff == cmcc_pkg::ST_WRITE;
  assign inhibit_time_pulse = write_time_window; // see R15
  // Zero bits of the register are inhibited across all 17 positions.
  assign inhibit_drive = inhibit_time_pulse ? ~dtr_ff
    : 17'h00000; // see R7, R14
  // Strobes are suppressed for an absent stack so it is never driven.
  assign rd_stb = read_time_window && cnt_ff == 5'h00
    && stack_ok; // see R2, R4
  assign wr_stb = write_time_window && wr_last && stack_ok; // see R7
  assign cpu_ready = state_ff == cmcc_pkg::ST_IDLE && !fill_arm; // see R16
  assign cpu_done = done_ff;
  assign cpu_rdata = rdata_ff;

  cmcc_core_array u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .addr(cyc_addr_ff),
    .rd_stb(rd_stb),
    .wr_stb(wr_stb),
    .inhibit(inhibit_drive),
    .sense(sense)
  );

  // --------------------------------------------------------------
  // Memory cycle
  // --------------------------------------------------------------

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_mar = mar_ff;
    nxt_cyc_addr = cyc_addr_ff;
    nxt_fill_addr = fill_addr_ff;
    nxt_dtr = dtr_ff;
    nxt_wdata = wdata_ff;
    nxt_wr_cyc = wr_cyc_ff;
    nxt_fill_cyc = fill_cyc_ff;
    nxt_acc = acc_ff;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    if (cpu_mar_load) begin
      nxt_mar = cpu_mar_in; // see R3
    end
    case (state_ff)
      cmcc_pkg::ST_IDLE: begin
        nxt_cnt = 5'h00;
        if (fill_arm) begin
          // Fill takes the cycle; a protected loader word is only
          // read and restored so it keeps its contents.
          nxt_cyc_addr = fill_addr_ff; // see R12
          nxt_wdata = disp_ff; // see R9
          nxt_wr_cyc = fill_write && (!loader_hit
            || ctrl_ff[`CMCC_CTRL_LDR_EN]); // see R11
          nxt_fill_cyc = 1'b1;
          nxt_dtr = 17'h00000;
          nxt_state = cmcc_pkg::ST_READ;
        end else if (cpu_req) begin
          nxt_cyc_addr = mar_ff; // see R3, R16
          nxt_wdata = cpu_sbus;
          nxt_wr_cyc = cpu_we;
          nxt_fill_cyc = 1'b0;
          nxt_dtr = 17'h00000;
          nxt_state = cmcc_pkg::ST_READ;
        end
      end
      cmcc_pkg::ST_READ: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (rd_last) begin
          // The sense pulse is only honoured inside the read window.
          if (wr_cyc_ff) begin
            nxt_dtr = {~^wdata_ff, wdata_ff}; // see R8, R14
          end else begin
            nxt_dtr = stack_ok ? sense : 17'h00000; // see R2, R5, R15
          end
          nxt_cnt = 5'h00;
          nxt_state = cmcc_pkg::ST_WRITE; // see R6
        end
      end
      cmcc_pkg::ST_WRITE: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (wr_last) begin
          nxt_cnt = 5'h00;
          nxt_state = cmcc_pkg::ST_DONE;
        end
      end
      cmcc_pkg::ST_DONE: begin
        if (fill_cyc_ff) begin
          if (!fill_write) begin
            nxt_acc = dtr_ff[15:0]; // see R13
          end
          nxt_fill_addr = (fill_addr_ff == top_addr) ? 15'h0000
            : fill_addr_ff + 15'h0001; // see R12
        end else begin
          nxt_done = 1'b1;
          nxt_rdata = dtr_ff[15:0];
        end
        nxt_state = cmcc_pkg::ST_IDLE; // see R16
      end
      default: begin
        nxt_state = cmcc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= cmcc_pkg::ST_IDLE;
      cnt_ff <= 5'h00;
      mar_ff <= 15'h0000;
      cyc_addr_ff <= 15'h0000;
      fill_addr_ff <= 15'h0000;
      dtr_ff <= 17'h00000;
      wdata_ff <= 16'h0000;
      wr_cyc_ff <= 1'b0;
      fill_cyc_ff <= 1'b0;
      acc_ff <= 16'h0000;
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      mar_ff <= nxt_mar;
      cyc_addr_ff <= nxt_cyc_addr;
      fill_addr_ff <= nxt_fill_addr;
      dtr_ff <= nxt_dtr;
      wdata_ff <= nxt_wdata;
      wr_cyc_ff <= nxt_wr_cyc;
      fill_cyc_ff <= nxt_fill_cyc;
      acc_ff <= nxt_acc;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_disp = disp_ff;
    nxt_cfg = cfg_ff;
    reg_werr = 1'b0;
    if (reg_wr) begin
      case (reg_waddr)
        `CMCC_OFF_CTRL: begin
          if (reg_wstrb[0]) begin
            nxt_ctrl = reg_wdata[3:0]; // see R10
          end
        end
        `CMCC_OFF_DISP: begin
          if (reg_wstrb[0]) begin
            nxt_disp[7:0] = reg_wdata[7:0]; // see R9
          end
          if (reg_wstrb[1]) begin
            nxt_disp[15:8] = reg_wdata[15:8];
          end
        end
        `CMCC_OFF_CFG: begin
          if (reg_wstrb[0]) begin
            nxt_cfg = reg_wdata[1:0]; // see R2
          end
        end
        `CMCC_OFF_STAT, `CMCC_OFF_ACC, `CMCC_OFF_DTR: begin
          reg_werr = 1'b0;
        end
        default: begin
          reg_werr = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    reg_rdata = 32'h0000_0000;
    reg_rerr = 1'b0;
    case (reg_raddr)
      `CMCC_OFF_CTRL: reg_rdata[3:0] = ctrl_ff;
      `CMCC_OFF_DISP: reg_rdata[15:0] = disp_ff;
      `CMCC_OFF_CFG: reg_rdata[1:0] = cfg_ff;
      `CMCC_OFF_STAT: begin
        reg_rdata[0] = state_ff != cmcc_pkg::ST_IDLE;
        reg_rdata[1] = fill_arm;
        reg_rdata[2] = cpu_halted;
        reg_rdata[30:16] = fill_addr_ff;
      end
      `CMCC_OFF_ACC: reg_rdata[15:0] = acc_ff;
      `CMCC_OFF_DTR: reg_rdata[16:0] = dtr_ff;
      default: reg_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `CMCC_CTRL_RST;
      disp_ff <= `CMCC_DISP_RST;
      cfg_ff <= `CMCC_CFG_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      disp_ff <= nxt_disp;
      cfg_ff <= nxt_cfg;
    end
  end
endmodule

// ===== sim/cmcc_top_properties.sv
`timescale 1ns/1ps
module cmcc_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Processor side
  input wire logic cpu_req,
  input wire logic cpu_ready,
  input wire logic cpu_done,
  // Core timing
  input wire logic read_time_window,
  input wire logic write_time_window,
  input wire logic inhibit_time_pulse,
  input wire logic [16:0] inhibit_drive
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // -----
  // Window length counters
  // -----
  logic [5:0] rd_cnt_ff;
  logic [5:0] nxt_rd_cnt;
  logic [5:0] wr_cnt_ff;
  logic [5:0] nxt_wr_cnt;
  // Fill cycles end without a done pulse, so only taken processor cycles are tracked.
  logic proc_ff;
  logic nxt_proc;
  always_comb begin
    nxt_rd_cnt = read_time_window ? rd_cnt_ff + 6'h01 : 6'h00;
    nxt_wr_cnt = write_time_window ? wr_cnt_ff + 6'h01 : 6'h00;
    nxt_proc = (cpu_req && cpu_ready) || (proc_ff && !cpu_done);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_cnt_ff <= 6'h00;
      wr_cnt_ff <= 6'h00;
      proc_ff <= 1'b0;
    end else begin
      rd_cnt_ff <= nxt_rd_cnt;
      wr_cnt_ff <= nxt_wr_cnt;
      proc_ff <= nxt_proc;
    end
  end
  // -----
  // Properties
  // -----
  property p_rd_len;
    $fell(read_time_window) |-> rd_cnt_ff == 6'h14;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read window length wrong");
  property p_wr_follow;
    $fell(read_time_window) |-> write_time_window;
  endproperty
  a_wr_follow: assert property (p_wr_follow) else $error("restore not after read");
  property p_wr_len;
    $fell(write_time_window) |-> wr_cnt_ff == 6'h14;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write window length wrong");
  property p_inh_in_wr;
    inhibit_time_pulse |-> write_time_window;
  endproperty
  a_inh_in_wr: assert property (p_inh_in_wr) else $error("inhibit outside write");
  property p_inh_idle;
    !inhibit_time_pulse |-> inhibit_drive == 17'h00000;
  endproperty
  a_inh_idle: assert property (p_inh_idle) else $error("inhibit drive without pulse");
  property p_done;
    $fell(write_time_window) && proc_ff |=> cpu_done;
  endproperty
  a_done: assert property (p_done) else $error("no done after restore");
  property p_take;
    cpu_req && cpu_ready |=> read_time_window;
  endproperty
  a_take: assert property (p_take) else $error("request not started");
  property p_busy;
    read_time_window || write_time_window |-> !cpu_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during a cycle");
  property p_inh_stable;
    inhibit_time_pulse && $past(inhibit_time_pulse) |-> $stable(inhibit_drive);
  endproperty
  a_inh_stable: assert property (p_inh_stable) else $error("inhibit drive moved");
  c_restore: cover property ($fell(write_time_window));
  c_inhibit: cover property (inhibit_time_pulse && inhibit_drive != 17'h00000);
  c_done: cover property (cpu_done);
endmodule

bind cmcc_top cmcc_chk cmcc_chk_inst (.aclk(aclk), .aresetn(aresetn), .cpu_req(cpu_req),
  .cpu_ready(cpu_ready), .cpu_done(cpu_done), .read_time_window(read_time_window),
  .write_time_window(write_time_window), .inhibit_time_pulse(inhibit_time_pulse),
  .inhibit_drive(inhibit_drive));

// ===== sim/cmcc_cpu_model.sv
`timescale 1ns/1ps
module cmcc_cpu_model (
  // Clock
  input wire logic aclk,
  // Answer from the memory
  input wire logic cpu_ready,
  input wire logic cpu_done,
  input wire logic [15:0] cpu_rdata,
  // Request to the memory
  output logic cpu_mar_load,
  output logic [14:0] cpu_mar_in,
  output logic cpu_req,
  output logic cpu_we,
  output logic [15:0] cpu_sbus
);
  initial begin
    cpu_mar_load = 1'b0;
    cpu_mar_in = 15'h0000;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_sbus = 16'h0000;
  end
  // Released lines show the inverse so a stale value is never mistaken for a held one.
  task access(input logic [14:0] a, input logic w, input logic [15:0] d, input int gap,
              output logic [15:0] q);
    int n;
    cpu_mar_in <= a;
    cpu_mar_load <= 1'b1;
    @(posedge aclk);
    cpu_mar_load <= 1'b0;
    cpu_mar_in <= ~a;
    repeat (gap) @(posedge aclk);
    // Ready is looked at mid-cycle, where it has settled for the coming edge.
    cpu_req <= 1'b1;
    cpu_we <= w;
    cpu_sbus <= d;
    n = 0;
    @(negedge aclk);
    while (!cpu_ready && n < 100) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    cpu_req <= 1'b0;
    cpu_sbus <= ~d;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!cpu_done && n < 60);
    q = cpu_rdata;
    @(posedge aclk);
  endtask
endmodule

// ===== sim/test_core_memory_cycle_control.sv
`timescale 1ns/1ps
`include "cmcc_params.svh"
module test_core_memory_cycle_control;
  logic aclk, aresetn, cpu_halted;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic cpu_mar_load, cpu_req, cpu_we, cpu_ready, cpu_done;
  logic [14:0] cpu_mar_in, k;
  logic [15:0] cpu_sbus, cpu_rdata, q;
  logic read_time_window, write_time_window, inhibit_time_pulse;
  logic [16:0] inhibit_drive;
  int errors, compares, cyc;
  localparam logic [14:0] AD [4] = '{15'h0000, 15'h1fff, 15'h2000, 15'h7fff};
  localparam logic [15:0] DV [4] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h0001};

  cmcc_top cmcc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_mar_load, .cpu_mar_in, .cpu_req, .cpu_we, .cpu_sbus,
    .cpu_halted, .cpu_ready, .cpu_done, .cpu_rdata, .read_time_window, .write_time_window,
    .inhibit_time_pulse, .inhibit_drive);
  cmcc_cpu_model cmcc_cpu_model_inst (.aclk, .cpu_ready, .cpu_done, .cpu_rdata, .cpu_mar_load,
    .cpu_mar_in, .cpu_req, .cpu_we, .cpu_sbus);

  // -----
  // Helpers
  // -----
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, aw_hit, w_hit;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      aw_hit = aw && s_axi_awready;
      w_hit = w && s_axi_wready;
      @(posedge aclk);
      if (aw_hit) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_hit) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task cpu(input logic [14:0] a, input logic w, input logic [15:0] d, input int g);
    cmcc_cpu_model_inst.access(a, w, d, g, q);
  endtask
  task poll(input logic idle, input logic [14:0] min);
    int n;
    n = 0;
    do begin
      axi_rd(`CMCC_OFF_STAT);
      n++;
    end while (n < 400 && (idle ? rd[0] : rd[30:16] < min));
  endtask

  // -----
  // Scenarios
  // -----
  task t_regs;
    axi_rd(`CMCC_OFF_CTRL);
    chk("ctrl reset", rd, 32'h00000000);
    axi_rd(`CMCC_OFF_CFG);
    chk("cfg reset", rd, 32'h00000003);
    axi_rd(8'h18);
    chk("unmapped resp", 32'(resp), 32'h00000002);
    axi_wr(`CMCC_OFF_DISP, 32'h0000beef);
    axi_rd(`CMCC_OFF_DISP);
    chk("test word", rd, 32'h0000beef);
  endtask
  task t_rw;
    for (int i = 0; i < 4; i++) begin
      cpu(AD[i], 1'b1, DV[i], i);
      chk("write return", 32'(q), 32'(DV[i]));
    end
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        cpu(AD[i], 1'b0, 16'h0000, 0);
        chk("read back", 32'(q), 32'(DV[i]));
      end
    end
    axi_rd(`CMCC_OFF_DTR);
    chk("transfer word", rd, {15'h0000, ~^DV[3], DV[3]});
    fork
      cpu(15'h0100, 1'b1, 16'h5a0f, 1);
      begin
        @(posedge aclk iff write_time_window);
        chk("inhibit", 32'(inhibit_drive), 32'h0000a5f0);
      end
    join
    axi_wr(`CMCC_OFF_CFG, 32'h00000000);
    cpu(15'h2000, 1'b1, 16'h1234, 0);
    cpu(15'h2000, 1'b0, 16'h0000, 0);
    chk("absent stack", 32'(q), 32'h00000000);
    axi_wr(`CMCC_OFF_CFG, 32'h00000003);
    cpu(15'h2000, 1'b0, 16'h0000, 2);
    chk("untouched stack", 32'(q), 32'h0000a5a5);
  endtask
  task t_fill;
    cpu_halted <= 1'b0;
    axi_wr(`CMCC_OFF_DISP, 32'h0000c3a5);
    axi_wr(`CMCC_OFF_CTRL, 32'h00000007);
    repeat (60) @(posedge aclk);
    axi_rd(`CMCC_OFF_STAT);
    chk("no fill running", rd & 32'h7fff0001, 32'h00000000);
    cpu_halted <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("ready while armed", 32'(cpu_ready), 32'h00000000);
    poll(1'b0, 15'h0003);
    axi_wr(`CMCC_OFF_CTRL, 32'h00000003);
    poll(1'b1, 15'h0000);
    k = rd[30:16];
    repeat (100) @(posedge aclk);
    axi_rd(`CMCC_OFF_STAT);
    chk("fill stopped", 32'(rd[30:16]), 32'(k));
    for (int i = 0; i < 3; i++) begin
      cpu(15'(i), 1'b0, 16'h0000, 0);
      chk("filled word", 32'(q), 32'h0000c3a5);
    end
  endtask
  task t_rloop;
    for (int i = 0; i < 8; i++) begin
      cpu(k + 15'(i), 1'b1, 16'h3c69, 0);
    end
    axi_wr(`CMCC_OFF_CTRL, 32'h00000006);
    poll(1'b0, k + 15'h0002);
    axi_wr(`CMCC_OFF_CTRL, 32'h00000002);
    poll(1'b1, 15'h0000);
    axi_rd(`CMCC_OFF_ACC);
    chk("accumulator", 32'(rd[15:0]), 32'h00003c69);
    cpu(k, 1'b0, 16'h0000, 0);
    chk("restored", 32'(q), 32'h00003c69);
    cpu(15'h0000, 1'b0, 16'h0000, 0);
    chk("read loop kept", 32'(q), 32'h0000c3a5);
  endtask

  // -----
  // Run control
  // -----
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      results;
    end
  end
  initial begin
    errors = 0;
    compares = 0;
    aresetn = 1'b0;
    cpu_halted = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_rw;
    t_fill;
    t_rloop;
    results;
  end
endmodule
